// File: hdl/fbcd_pkg.sv
package fbcd_pkg;

    // ----------------------------------------
    // time base
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int CNT_W = 13;

    // ----------------------------------------
    // command pulse times (us) and decision thresholds
    // ----------------------------------------
    localparam int QUERY_PULSE_TIME_US = 160;
    localparam int LATCH_CLEAR_PULSE_TIME_US = 2 * QUERY_PULSE_TIME_US;
    localparam int QUERY_MIN_US = 120;
    localparam int CLASS_SPLIT_US = 240;
    localparam int PULSE_MAX_US = 480;
    // least times round up to whole cycles
    localparam logic [CNT_W-1:0] QUERY_MIN_CYC =
        CNT_W'((QUERY_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CLASS_SPLIT_CYC =
        CNT_W'((CLASS_SPLIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // longest time rounds down
    localparam logic [CNT_W-1:0] PULSE_MAX_CYC_DEF =
        CNT_W'((PULSE_MAX_US * 1000) / CLK_PERIOD_NS);

    // ----------------------------------------
    // transmit timing (us)
    // ----------------------------------------
    localparam int ONE_BIT_HIGH_TIME_US = 40;
    localparam int ZERO_BIT_HIGH_TIME_US = 10;
    localparam int BIT_LOW_TIME_US = 10;
    localparam int STEADY_TIME_US = 80;
    localparam int IDLE_TIME_US = 2 * STEADY_TIME_US;
    localparam int ARB_CHECK_TIME_US = 20;
    localparam int ARBITRATION_LOW_TIME_ID1_US = 40;
    localparam int ARBITRATION_LOW_TIME_ID2_US = 60;
    localparam int ARBITRATION_LOW_TIME_ID3_US = 80;
    localparam logic [CNT_W-1:0] ONE_CYC = CNT_W'(ONE_BIT_HIGH_TIME_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ZERO_CYC = CNT_W'(ZERO_BIT_HIGH_TIME_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LO_CYC = CNT_W'(BIT_LOW_TIME_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SS_CYC = CNT_W'(STEADY_TIME_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] IDLE_CYC = CNT_W'(IDLE_TIME_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CHECK_CYC = CNT_W'(ARB_CHECK_TIME_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ARB1_CYC =
        CNT_W'(ARBITRATION_LOW_TIME_ID1_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ARB2_CYC =
        CNT_W'(ARBITRATION_LOW_TIME_ID2_US * 1000 / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ARB3_CYC =
        CNT_W'(ARBITRATION_LOW_TIME_ID3_US * 1000 / CLK_PERIOD_NS);
    // sync delay before the released line can be seen high
    localparam logic [CNT_W-1:0] SYNC_SKIP_CYC = 13'h0003;

    // ----------------------------------------
    // words, ids, straps
    // ----------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] FRAME_BITS = 4'h8;
    localparam logic [1:0] SETTLE_DONE = 2'h3;
    localparam logic [1:0] ID_ONE = 2'h1;
    localparam logic [1:0] ID_TWO = 2'h2;
    localparam logic [1:0] ID_THREE = 2'h3;

    typedef struct packed {
        logic hs_overcurrent;
        logic ls_overcurrent;
        logic [1:0] ls_thermal;
        logic [2:0] system_level;
    } fbcd_status_type;

    typedef enum logic [1:0] {
        STRAP_LOW_SIDE = 2'b00,
        STRAP_FLOAT = 2'b01,
        STRAP_SIG_GND = 2'b10
    } fbcd_strap_type;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_WAIT = 3'b001,
        TX_ARB = 3'b010,
        TX_CHECK = 3'b011,
        TX_HIGH = 3'b100,
        TX_LOW = 3'b101,
        TX_GAP = 3'b110
    } fbcd_tx_state_type;

endpackage : fbcd_pkg

// File: hdl/fbcd_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module fbcd_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (flush)
        begin
            wr_d = '0;
            rd_d = '0;
        end
        else
        begin
            if (push)
                wr_d = wr_q + 1'b1;
            if (pop)
                rd_d = rd_q + 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule : fbcd_fifo
`default_nettype wire

// File: hdl/fbcd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module fbcd_decoder
    import fbcd_pkg::*;
#(
    parameter logic [CNT_W-1:0] PULSE_MAX_CYC = PULSE_MAX_CYC_DEF
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // shared status line
    input wire logic status_line_i,
    output logic status_line_o,
    output logic status_line_oe,
    // straps and configuration pins
    input wire logic [1:0] id_strap,
    input wire logic system_monitor_bus_en,
    // power-up sequencer
    input wire logic power_up_done,
    output logic mission_mode,
    output logic seq_restart,
    // fault logic
    input wire fbcd_status_type fault_status,
    output logic ot_latch_clear,
    output fbcd_status_type status_reg,
    output logic [1:0] device_id
);

    // ----------------------------------------
    // decoding helpers
    // ----------------------------------------
    function automatic logic [1:0] fbcd_id_of(input logic [1:0] strap);
        unique case (strap)
            STRAP_LOW_SIDE: fbcd_id_of = ID_ONE;
            STRAP_SIG_GND: fbcd_id_of = ID_THREE;
            default: fbcd_id_of = ID_TWO;
        endcase
    endfunction : fbcd_id_of

    function automatic logic [CNT_W-1:0] fbcd_arb_cycles(input logic [1:0] id);
        unique case (id)
            ID_ONE: fbcd_arb_cycles = ARB1_CYC;
            ID_THREE: fbcd_arb_cycles = ARB3_CYC;
            default: fbcd_arb_cycles = ARB2_CYC;
        endcase
    endfunction : fbcd_arb_cycles

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic line_s1_q, line_s2_q, line_prev_q;
    logic [1:0] strap_s1_q, strap_s2_q;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            line_s1_q <= 1'b1;
            line_s2_q <= 1'b1;
            line_prev_q <= 1'b1;
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
        end
        else
        begin
            line_s1_q <= status_line_i;
            line_s2_q <= line_s1_q;
            line_prev_q <= line_s2_q;
            strap_s1_q <= id_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // ----------------------------------------
    // id strap capture
    // ----------------------------------------
    logic [1:0] settle_q, settle_d, device_id_q, device_id_d;
    logic id_valid_q, id_valid_d;
    logic [CNT_W-1:0] arb_cyc_q, arb_cyc_d;

    always_comb
    begin
        settle_d = settle_q;
        id_valid_d = id_valid_q;
        device_id_d = device_id_q;
        arb_cyc_d = arb_cyc_q;
        if (settle_q != SETTLE_DONE)
            settle_d = settle_q + 2'h1;
        // sampled once, after the synchroniser has filled
        else if (!id_valid_q)
        begin
            id_valid_d = 1'b1;
            device_id_d = fbcd_id_of(strap_s2_q);
            arb_cyc_d = fbcd_arb_cycles(fbcd_id_of(strap_s2_q));
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            settle_q <= 2'h0;
            id_valid_q <= 1'b0;
            device_id_q <= ID_TWO;
            arb_cyc_q <= ARB2_CYC;
        end
        else
        begin
            settle_q <= settle_d;
            id_valid_q <= id_valid_d;
            device_id_q <= device_id_d;
            arb_cyc_q <= arb_cyc_d;
        end
    end

    // ----------------------------------------
    // command receiver
    // ----------------------------------------
    fbcd_tx_state_type tx_state_q, tx_state_d;
    logic mission_q, mission_d;
    logic [CNT_W-1:0] low_cnt_q, low_cnt_d;
    logic rx_en, rx_rise, query_cmd, clear_cmd;

    // our own arbitration and bit lows must not be read as commands
    assign rx_en = mission_q && (tx_state_q inside {TX_IDLE, TX_WAIT, TX_GAP});
    assign rx_rise = line_s2_q && !line_prev_q;
    assign query_cmd = rx_en && rx_rise && (low_cnt_q >= QUERY_MIN_CYC)
                       && (low_cnt_q < CLASS_SPLIT_CYC);
    assign clear_cmd = rx_en && rx_rise && (low_cnt_q >= CLASS_SPLIT_CYC)
                       && (low_cnt_q <= PULSE_MAX_CYC);

    always_comb
    begin
        low_cnt_d = '0;
        // saturating, so a stuck-low line never wraps into a command
        if (rx_en && !line_s2_q)
            low_cnt_d = (low_cnt_q == '1) ? low_cnt_q : low_cnt_q + 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            low_cnt_q <= '0;
        else
            low_cnt_q <= low_cnt_d;
    end

    // ----------------------------------------
    // mission mode and status register
    // ----------------------------------------
    fbcd_status_type status_q, status_d, status_eff;
    logic pend_q, pend_d, seq_restart_q, ot_clear_q, entry, push, fifo_in_ready;

    assign entry = power_up_done && id_valid_q && !mission_q;
    assign push = pend_q && mission_q && fifo_in_ready;

    always_comb
    begin
        status_eff = fault_status;
        if (!system_monitor_bus_en)
            status_eff.system_level = 3'h0;
        status_d = clear_cmd ? '0 : status_eff;
        mission_d = mission_q;
        if (clear_cmd)
            mission_d = 1'b0;
        else if (entry)
            mission_d = 1'b1;
        // a new event wins over the push that retires the old one
        pend_d = pend_q && !push;
        if (clear_cmd)
            pend_d = 1'b0;
        else if (mission_q && (query_cmd || status_d != status_q))
            pend_d = 1'b1;
        else if (entry)
            pend_d = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            status_q <= '0;
            mission_q <= 1'b0;
            pend_q <= 1'b0;
            seq_restart_q <= 1'b0;
            ot_clear_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            mission_q <= mission_d;
            pend_q <= pend_d;
            seq_restart_q <= clear_cmd;
            ot_clear_q <= clear_cmd;
        end
    end

    // ----------------------------------------
    // report queue
    // ----------------------------------------
    logic fifo_out_valid, fifo_out_ready;
    fbcd_status_type fifo_out;

    // a clear drops every queued report along with the register
    fbcd_fifo #(
        .WIDTH($bits(fbcd_status_type)),
        .DEPTH(FIFO_DEPTH)
    ) fbcd_fifo_inst (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(clear_cmd),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(status_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    logic [CNT_W-1:0] cnt_q, cnt_d, high_lim;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bits_q, bits_d;
    logic oe_q, oe_d, drv_q;

    assign fifo_out_ready = mission_q && (tx_state_q == TX_IDLE);
    assign high_lim = shift_q[0] ? ONE_CYC : ZERO_CYC;

    always_comb
    begin
        tx_state_d = tx_state_q;
        cnt_d = cnt_q + 1'b1;
        shift_d = shift_q;
        bits_d = bits_q;
        oe_d = oe_q;
        unique case (tx_state_q)
            TX_IDLE:
            begin
                cnt_d = '0;
                if (fifo_out_valid && fifo_out_ready)
                begin
                    shift_d = {~^fifo_out, fifo_out};
                    tx_state_d = TX_WAIT;
                end
            end
            TX_WAIT:
            begin
                if (!line_s2_q)
                    cnt_d = '0;
                else if (cnt_q == SS_CYC - 1'b1)
                begin
                    cnt_d = '0;
                    oe_d = 1'b1;
                    tx_state_d = TX_ARB;
                end
            end
            TX_ARB:
                if (cnt_q == arb_cyc_q - 1'b1)
                begin
                    cnt_d = '0;
                    oe_d = 1'b0;
                    tx_state_d = TX_CHECK;
                end
            TX_CHECK:
                // lost arbitration: retry from the steady wait
                if (cnt_q >= SYNC_SKIP_CYC && !line_s2_q)
                begin
                    cnt_d = '0;
                    tx_state_d = TX_WAIT;
                end
                else if (cnt_q == CHECK_CYC - 1'b1)
                begin
                    cnt_d = '0;
                    bits_d = FRAME_BITS;
                    tx_state_d = TX_HIGH;
                end
            TX_HIGH:
                if (cnt_q == high_lim - 1'b1)
                begin
                    cnt_d = '0;
                    oe_d = 1'b1;
                    tx_state_d = TX_LOW;
                end
            TX_LOW:
                if (cnt_q == LO_CYC - 1'b1)
                begin
                    cnt_d = '0;
                    oe_d = 1'b0;
                    shift_d = {1'b0, shift_q[7:1]};
                    bits_d = bits_q - 4'h1;
                    tx_state_d = (bits_q == 4'h1) ? TX_GAP : TX_HIGH;
                end
            TX_GAP:
                if (cnt_q == IDLE_CYC - 1'b1)
                    tx_state_d = TX_IDLE;
            default:
            begin
                oe_d = 1'b0;
                tx_state_d = TX_IDLE;
            end
        endcase
        if (!mission_d)
        begin
            oe_d = 1'b0;
            tx_state_d = TX_IDLE;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            tx_state_q <= TX_IDLE;
            cnt_q <= '0;
            shift_q <= 8'h00;
            bits_q <= 4'h0;
            oe_q <= 1'b0;
            drv_q <= 1'b0;
        end
        else
        begin
            tx_state_q <= tx_state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            bits_q <= bits_d;
            oe_q <= oe_d;
            drv_q <= 1'b0;
        end
    end

    assign status_line_o = drv_q;
    assign status_line_oe = oe_q;
    assign mission_mode = mission_q;
    assign seq_restart = seq_restart_q;
    assign ot_latch_clear = ot_clear_q;
    assign status_reg = status_q;
    assign device_id = device_id_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_premission_no_cmd: assert property (!mission_q |=> !ot_clear_q && !seq_restart_q)
        else $error("command taken outside mission mode");
    a_query_pends: assert property (query_cmd |=> pend_q && mission_q)
        else $error("status query not turned into a report");
    a_clear_status: assert property (clear_cmd |=> status_q == '0 && ot_clear_q ##1 !ot_clear_q)
        else $error("clear did not empty the status register");
    a_leave_mission: assert property (clear_cmd |=> !mission_q && seq_restart_q)
        else $error("clear did not restart power-up sequencing");
    a_open_drain: assert property (oe_q |-> status_line_o == 1'b0
            && tx_state_q inside {TX_ARB, TX_LOW})
        else $error("line driven outside a low phase");
    a_id_map: assert property ($rose(id_valid_q) |-> device_id_q == fbcd_id_of($past(strap_s2_q))
            && arb_cyc_q == fbcd_arb_cycles(device_id_q))
        else $error("id or arbitration time does not match the strap");
    a_arb_length: assert property ($rose(oe_q) && tx_state_q == TX_ARB |-> oe_q [*8])
        else $error("arbitration low released too early");
    a_change_report: assert property (mission_q && !clear_cmd && status_d != status_q
            |=> pend_q)
        else $error("status change not reported");
    a_ready_word: assert property (fifo_out_valid && fifo_out_ready && fifo_out == '0
            |=> shift_q == 8'h80)
        else $error("ready word not all zero with parity set");
    a_word_parity: assert property (tx_state_q == TX_CHECK |-> ^shift_q == 1'b1)
        else $error("frame parity is not odd");
    a_bit_high_len: assert property ($past(tx_state_q) == TX_HIGH && tx_state_q == TX_LOW
            |-> $past(cnt_q) == ($past(shift_q[0]) ? ONE_CYC : ZERO_CYC) - 1'b1)
        else $error("bit high time wrong");
    a_bit_low_len: assert property ($past(tx_state_q) == TX_LOW && tx_state_q != TX_LOW
            |-> $past(cnt_q) == LO_CYC - 1'b1)
        else $error("bit low time wrong");
    a_ignore_short: assert property (rx_rise && low_cnt_q < QUERY_MIN_CYC
            |-> !query_cmd && !clear_cmd)
        else $error("short pulse taken as a command");

    c_query: cover property (query_cmd ##1 pend_q);
    c_clear: cover property (clear_cmd ##1 seq_restart_q);
    c_frame_done: cover property (tx_state_q == TX_LOW ##1 tx_state_q == TX_GAP);
    c_arb_lost: cover property (tx_state_q == TX_CHECK ##1 tx_state_q == TX_WAIT);

endmodule : fbcd_decoder
`default_nettype wire

// File: testbench/fbcd_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
module fbcd_mcu_model
    import fbcd_pkg::*;
(
    // clock and shared line
    input wire logic mclk,
    input wire logic line_i,
    output logic drive_low,
    // decoded frames
    output logic rx_done,
    output logic [7:0] rx_word,
    output logic [12:0] rx_arb,
    output logic rx_ok
);
    // ----------------------------------------
    // command pulses and frame capture
    // ----------------------------------------
    task automatic send_pulse(input int n);
        @(posedge mclk);
        #10 drive_low = 1'b1;
        repeat (n) @(posedge mclk);
        #10 drive_low = 1'b0;
    endtask : send_pulse

    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (line_i === lvl)
        begin
            n++;
            @(posedge mclk);
        end
    endtask : run_len

    initial
    begin : capture
        int h;
        int l;
        drive_low = 1'b0;
        rx_done = 1'b0;
        forever
        begin
            @(posedge mclk);
            // own pulses are not frames
            if (line_i === 1'b0 && drive_low === 1'b0)
            begin
                run_len(1'b0, h);
                rx_arb = 13'(h);
                rx_ok = 1'b1;
                for (int i = 0; i < 8; i++)
                begin
                    run_len(1'b1, h);
                    run_len(1'b0, l);
                    // first high also holds the post-arbitration check
                    if (i == 0)
                        h = h - int'(CHECK_CYC);
                    rx_word[i] = h > (int'(ONE_CYC) + int'(ZERO_CYC)) / 2;
                    if ((h != int'(ONE_CYC) && h != int'(ZERO_CYC)) || l != int'(LO_CYC))
                        rx_ok = 1'b0;
                end
                rx_done = 1'b1;
                #10 rx_done = 1'b0;
            end
        end
    end
endmodule : fbcd_mcu_model
`default_nettype wire

// File: testbench/fbcd_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module fbcd_decoder_tb_top import fbcd_pkg::*;;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int Q_CYC = QUERY_PULSE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int C_CYC = LATCH_CLEAR_PULSE_TIME_US * 1000 / CLK_PERIOD_NS;
    logic mclk, rst_n, bus_en, pwr_done, line_o, line_oe, mission, restart, clr;
    logic [1:0] id_strap;
    logic [1:0] dev_id;
    fbcd_status_type fault;
    fbcd_status_type st_reg;
    logic mcu_low, rx_done, rx_ok;
    logic [7:0] rx_word;
    logic [12:0] rx_arb;
    logic o_bad = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int clr_cnt = 0;
    int rst_cnt = 0;
    logic [21:0] exp_q[$];
    // pull-up: high unless some party pulls low
    wire line = ~(line_oe | mcu_low);

    fbcd_decoder #(.PULSE_MAX_CYC(PULSE_MAX_CYC_DEF)) fbcd_decoder_inst (
        .mclk(mclk), .rst_n(rst_n), .status_line_i(line), .status_line_o(line_o),
        .status_line_oe(line_oe), .id_strap(id_strap), .system_monitor_bus_en(bus_en),
        .power_up_done(pwr_done), .mission_mode(mission), .seq_restart(restart),
        .fault_status(fault), .ot_latch_clear(clr), .status_reg(st_reg), .device_id(dev_id)
    );
    fbcd_mcu_model fbcd_mcu_model_inst (
        .mclk(mclk), .line_i(line), .drive_low(mcu_low), .rx_done(rx_done),
        .rx_word(rx_word), .rx_arb(rx_arb), .rx_ok(rx_ok)
    );

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ----------------------------------------
    // checking
    // ----------------------------------------
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_frame(input logic [21:0] exp, input logic [21:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD frame expected %h seen %h", exp, got);
        end
    endtask : chk_frame

    function automatic logic [21:0] frame_of(input logic [6:0] w, input logic [12:0] arb);
        return {1'b1, arb, ~^w, w};
    endfunction : frame_of

    always @(posedge rx_done)
    begin
        if (exp_q.size() != 0)
            chk_frame(exp_q.pop_front(), {rx_ok, rx_arb, rx_word});
        else
            chk_frame(22'h000000, {rx_ok, rx_arb, rx_word});
    end

    always @(posedge mclk)
    begin
        if (clr === 1'b1)
            clr_cnt++;
        if (restart === 1'b1)
            rst_cnt++;
        if (rst_n === 1'b1 && line_o !== 1'b0)
            o_bad = 1'b1;
    end

    // the fault latch outside the block drops on the clear strobe
    always @(posedge clr) fault <= '0;

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask : tick

    // long enough for a wrongly started frame to show up before moving on
    task automatic wait_idle();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 9000)
        begin
            n++;
            tick(1);
        end
        chk_val("pending frames", 16'h0000, 16'(exp_q.size()));
        tick(3800);
    endtask : wait_idle

    task automatic enter_mission();
        pwr_done = 1'b1;
        tick(2);
        pwr_done = 1'b0;
    endtask : enter_mission

    initial
    begin : main
        logic [12:0] arb_t[3];
        logic [6:0] f;
        arb_t = '{ARB1_CYC, ARB2_CYC, ARB3_CYC};
        rst_n = 1'b0;
        id_strap = 2'h0;
        bus_en = 1'b1;
        pwr_done = 1'b0;
        fault = '0;
        void'($urandom(32'h308F02B7));
        for (int s = 0; s < 3; s++)
        begin
            rst_n = 1'b0;
            id_strap = 2'(s);
            tick(8);
            rst_n = 1'b1;
            tick(12);
            if (s == 0)
            begin
                fbcd_mcu_model_inst.send_pulse(Q_CYC);
                wait_idle();
            end
            chk_val("device id", 16'(s + 1), 16'(dev_id));
            exp_q.push_back(frame_of(7'h00, arb_t[s]));
            enter_mission();
            chk_val("mission", 16'h0001, 16'(mission));
            wait_idle();
        end
        f = 7'($urandom) | 7'h01;
        exp_q.push_back(frame_of(f, ARB3_CYC));
        fault = f;
        wait_idle();
        chk_val("status", 16'(f), 16'(st_reg));
        exp_q.push_back(frame_of(f, ARB3_CYC));
        fbcd_mcu_model_inst.send_pulse(Q_CYC);
        wait_idle();
        fbcd_mcu_model_inst.send_pulse(800);
        wait_idle();
        exp_q.push_back(frame_of(f & 7'h78, ARB3_CYC));
        bus_en = 1'b0;
        wait_idle();
        fbcd_mcu_model_inst.send_pulse(C_CYC);
        tick(10);
        chk_val("clear pulses", 16'h0101, {8'(clr_cnt), 8'(rst_cnt)});
        chk_val("after clear", 16'h0000, {8'(mission), 1'b0, st_reg});
        fbcd_mcu_model_inst.send_pulse(Q_CYC);
        wait_idle();
        exp_q.push_back(frame_of(7'h00, ARB3_CYC));
        enter_mission();
        wait_idle();
        exp_q.push_back(frame_of(7'h00, ARB3_CYC));
        fbcd_mcu_model_inst.send_pulse(Q_CYC);
        wait_idle();
        chk_val("drive value", 16'h0000, 16'(o_bad));
        test_done();
    end

    initial
    begin : watchdog
        repeat (98000) @(posedge mclk);
        fails++;
        test_done();
    end
endmodule : fbcd_decoder_tb_top
`default_nettype wire
